// ===== alarm_pkg.sv
// alarm interface card constants: read-command offsets, status bit positions, timing
// assumes a 20 MHz system clock
package alarm_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam logic [5:0] OFF_ID_LO = 6'h00;
  localparam logic [5:0] OFF_ID_HI = 6'h01;
  localparam logic [5:0] OFF_STAT_LO = 6'h04;
  localparam logic [5:0] OFF_STAT_HI = 6'h05;
  localparam logic [5:0] CMD_SWMIN_SET = 6'h20;
  localparam logic [5:0] CMD_SWMIN_CLR = 6'h21;
  localparam logic [5:0] CMD_SWMAJ_SET = 6'h22;
  localparam logic [5:0] CMD_SWMAJ_CLR = 6'h23;
  localparam logic [5:0] CMD_SAN_EN = 6'h24;
  localparam logic [5:0] CMD_SAN_DIS = 6'h25;
  localparam logic [5:0] CMD_SAN_NOP = 6'h26;
  localparam logic [5:0] CMD_SAN_CLR = 6'h27;
  localparam logic [5:0] CMD_INH_SET = 6'h28;
  localparam logic [5:0] CMD_INH_CLR = 6'h29;
  localparam logic [5:0] CMD_ACF_SET = 6'h2A;
  localparam logic [5:0] CMD_ACF_CLR = 6'h2B;
  localparam logic [5:0] CMD_LOWB_SET = 6'h2C;
  localparam logic [5:0] CMD_LOWB_CLR = 6'h2D;
  localparam logic [5:0] CMD_EXTMAJ_SET = 6'h2E;
  localparam logic [5:0] CMD_EXTMAJ_CLR = 6'h2F;
  localparam logic [5:0] CMD_EXTMIN_SET = 6'h30;
  localparam logic [5:0] CMD_EXTMIN_CLR = 6'h31;
  localparam logic [5:0] CMD_SEC_SET = 6'h32;
  localparam logic [5:0] CMD_SEC_CLR = 6'h33;
  localparam logic [5:0] CMD_FIRST_SET = 6'h34;
  localparam logic [5:0] CMD_FIRST_CLR = 6'h35;
  localparam logic [5:0] CMD_INT_CLR = 6'h36;
  localparam logic [5:0] CMD_SYS_RESET = 6'h37;
  localparam logic [5:0] CMD_DTR_UART = 6'h3E;
  localparam logic [5:0] CMD_DTR_FORCE = 6'h3F;
  localparam int B_SWMIN = 0;
  localparam int B_SWMAJ = 1;
  localparam int B_SANEN = 2;
  localparam int B_RESTART_N = 3;
  localparam int B_INHIBIT = 4;
  localparam int B_ACFAIL = 5;
  localparam int B_LOWBAT = 6;
  localparam int B_EXTMAJ = 7;
  localparam int B_EXTMIN = 8;
  localparam int B_SECOND = 9;
  localparam int B_FIRST = 10;
  localparam int B_DTR_UART = 15;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam int CLK_HZ = 20000000;
  localparam int RESTART_US10 = 1275000;
  localparam int RESTART_CYC = RESTART_US10 / 10 * (CLK_HZ / 1000000);
  localparam int SANITY_CYC_DEF = 40000000;
  localparam int CNT_W = 32;
endpackage

// ===== alarm_interface_read_command_unit.sv
// alarm interface card: read-only command decoder, status word, sanity timer, console mux
// assumes host read strobe and address are synchronous to MCLK; external pins are async
//
// Operation
// - only host reads are accepted; the read address selects the action
// - reads at identity offsets return the fixed board identity code
// - reads at status offsets return the 16-bit alarm status word
// - offsets 0x20/0x21 set/clear software minor alarm, bit 00
// - offsets 0x22/0x23 set/clear software major alarm, bit 01
// - offsets 0x24/0x25 enable/disable sanity timer, bit 02
// - 0x27 restarts sanity timer, bit 03 low 127.5 ms; 0x26 does nothing
// - offsets 0x28/0x29 set/clear alarm inhibit, bit 04, blocking the major and minor alarm outputs
// - offsets 0x2A/0x2B force/clear AC failure flag, bit 05
// - offsets 0x2C/0x2D force/clear low battery flag, bit 06
// - offsets 0x2E/0x2F force/clear external major flag, bit 07
// - offsets 0x30/0x31 force/clear external minor flag, bit 08
// - offsets 0x32/0x33 force/clear second-timeout flag, bit 09
// - 0x34 sets bit 10 and interrupt; 0x35 clears bit; 0x36 clears interrupt
// - read at 0x37 drives the bus reset request
// - 0x3E gives DTR to system UART; 0x3F forces DTR, the reset default
// - status bit 15 is 0 when DTR forced, 1 when UART controls
// - status bits 11-14 reserved zero; offsets 0x38-0x3D do nothing
// - bit 09 shows second sanity expiry, bit 10 first expiry interrupt
// - carrier levels steer the console mux; terminal A alone passes only A
// - terminal A has priority; both high B mirrors; both low the console hears only B, neither terminal is sent
// - first expiry interrupts and latches bit 10; second: major, bit 09, reset
// - low battery with AC failure set interrupts and raises major alarm
// - software alarms drive alarm outputs and status, nothing else
`timescale 1ns/10ps
`default_nettype none
module alarm_interface_read_command_unit
  import alarm_pkg::*;
#(
  parameter int SANITY_CYC = SANITY_CYC_DEF,
  parameter int RESTART_CYCLES = RESTART_CYC,
  parameter logic [15:0] BOARD_IDENTITY = 16'h5A3C // arbitrary identity value
)(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic RD_STB,
  input wire logic [5:0] RD_ADDR,
  output logic [15:0] RD_DATA,
  output logic HOST_INTERRUPT_N,
  output logic RESET_REQUEST_N,
  output logic MAJOR_ALARM,
  output logic MINOR_ALARM,
  input wire logic AC_FAIL_N,
  input wire logic LOW_BATTERY_N,
  input wire logic EXT_MAJOR_N,
  input wire logic EXT_MINOR_N,
  input wire logic TERMINAL_A_CARRIER,
  input wire logic TERMINAL_B_CARRIER,
  input wire logic CONSOLE_TXD,
  output logic CONSOLE_RXD,
  input wire logic UART_DTR,
  output logic REMOTE_TERMINAL_A_TXD,
  input wire logic REMOTE_TERMINAL_A_RXD,
  output logic REMOTE_TERMINAL_B_TXD,
  input wire logic REMOTE_TERMINAL_B_RXD,
  output logic REMOTE_TERMINAL_A_DTR,
  output logic REMOTE_TERMINAL_B_DTR
);

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  function automatic logic hit(input logic stb, input logic [5:0] a, input logic [5:0] c);
    hit = stb && (a == c);
  endfunction

  // the bus has no write path, so every access is a read; the address is the command
  logic [5:0] cmd;
  assign cmd = RD_ADDR;
  wire swmin_set = hit(RD_STB, cmd, CMD_SWMIN_SET);
  wire swmin_clr = hit(RD_STB, cmd, CMD_SWMIN_CLR);
  wire swmaj_set = hit(RD_STB, cmd, CMD_SWMAJ_SET);
  wire swmaj_clr = hit(RD_STB, cmd, CMD_SWMAJ_CLR);
  wire san_en = hit(RD_STB, cmd, CMD_SAN_EN);
  wire san_dis = hit(RD_STB, cmd, CMD_SAN_DIS);
  wire san_clr = hit(RD_STB, cmd, CMD_SAN_CLR);
  wire inh_set = hit(RD_STB, cmd, CMD_INH_SET);
  wire inh_clr = hit(RD_STB, cmd, CMD_INH_CLR);
  wire acf_set = hit(RD_STB, cmd, CMD_ACF_SET);
  wire acf_clr = hit(RD_STB, cmd, CMD_ACF_CLR);
  wire lowb_set = hit(RD_STB, cmd, CMD_LOWB_SET);
  wire lowb_clr = hit(RD_STB, cmd, CMD_LOWB_CLR);
  wire emaj_set = hit(RD_STB, cmd, CMD_EXTMAJ_SET);
  wire emaj_clr = hit(RD_STB, cmd, CMD_EXTMAJ_CLR);
  wire emin_set = hit(RD_STB, cmd, CMD_EXTMIN_SET);
  wire emin_clr = hit(RD_STB, cmd, CMD_EXTMIN_CLR);
  wire sec_set = hit(RD_STB, cmd, CMD_SEC_SET);
  wire sec_clr = hit(RD_STB, cmd, CMD_SEC_CLR);
  wire first_set = hit(RD_STB, cmd, CMD_FIRST_SET);
  wire first_clr = hit(RD_STB, cmd, CMD_FIRST_CLR);
  wire int_clr = hit(RD_STB, cmd, CMD_INT_CLR);
  wire sys_rst = hit(RD_STB, cmd, CMD_SYS_RESET);
  wire dtr_uart = hit(RD_STB, cmd, CMD_DTR_UART);
  wire dtr_force = hit(RD_STB, cmd, CMD_DTR_FORCE);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers for the external closures (active low)

  logic [3:0] ext_s1_reg;
  logic [3:0] ext_s2_reg;
  logic [3:0] ext_d_reg;
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ext_s1_reg <= 4'hF;
      ext_s2_reg <= 4'hF;
      ext_d_reg <= 4'hF;
    end
    else
    begin
      ext_s1_reg <= {EXT_MINOR_N, EXT_MAJOR_N, LOW_BATTERY_N, AC_FAIL_N};
      ext_s2_reg <= ext_s1_reg;
      ext_d_reg <= ext_s2_reg;
    end
  end
  // closures latch on the falling edge so a held contact can still be cleared
  wire [3:0] ext_fall = ext_d_reg & ~ext_s2_reg;
  wire acf_ev = ext_fall[0];
  wire lowb_ev = ext_fall[1];
  wire emaj_ev = ext_fall[2];
  wire emin_ev = ext_fall[3];

  ////////////////////////////////////////////////////////////////////////////
  // sanity timer: counts while enabled, restart reloads; two expiries

  logic [CNT_W-1:0] san_cnt_reg;
  logic [CNT_W-1:0] san_cnt_next;
  logic san_seen_first_reg;
  logic [CNT_W-1:0] rst_cnt_reg;
  logic sanen_reg;
  wire san_expire = sanen_reg && (san_cnt_reg == CNT_W'(SANITY_CYC - 1));
  wire exp1 = san_expire && !san_seen_first_reg;
  wire exp2 = san_expire && san_seen_first_reg;
  always_comb
  begin
    if (!sanen_reg || san_clr || san_expire)
      san_cnt_next = '0;
    else
      san_cnt_next = san_cnt_reg + CNT_W'(1);
  end
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      san_cnt_reg <= '0;
      san_seen_first_reg <= 1'b0;
      rst_cnt_reg <= '0;
    end
    else
    begin
      san_cnt_reg <= san_cnt_next;
      if (san_clr || !sanen_reg)
        san_seen_first_reg <= 1'b0;
      else if (exp1)
        san_seen_first_reg <= 1'b1;
      if (san_clr)
        rst_cnt_reg <= CNT_W'(RESTART_CYCLES);
      else if (rst_cnt_reg != '0)
        rst_cnt_reg <= rst_cnt_reg - CNT_W'(1);
    end
  end
  wire restart_n = (rst_cnt_reg == '0);

  ////////////////////////////////////////////////////////////////////////////
  // status flags: hardware set wins over a clearing read

  logic swmin_reg, swmaj_reg, inh_reg, acf_reg, lowb_reg, emaj_reg, emin_reg;
  logic sec_reg, first_reg, int_reg, dtr_uart_reg, rqrst_reg, crit_major_reg;
  // low battery with AC failure already latched interrupts and raises the major alarm, with no reset request
  wire lowb_crit = lowb_ev && acf_reg;
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      swmin_reg <= 1'b0;
      swmaj_reg <= 1'b0;
      sanen_reg <= 1'b0;
      inh_reg <= 1'b0;
      acf_reg <= 1'b0;
      lowb_reg <= 1'b0;
      emaj_reg <= 1'b0;
      emin_reg <= 1'b0;
      sec_reg <= 1'b0;
      first_reg <= 1'b0;
      int_reg <= 1'b0;
      dtr_uart_reg <= 1'b0;
      rqrst_reg <= 1'b0;
      crit_major_reg <= 1'b0;
    end
    else
    begin
      swmin_reg <= swmin_set | (swmin_reg & ~swmin_clr);
      swmaj_reg <= swmaj_set | (swmaj_reg & ~swmaj_clr);
      sanen_reg <= san_en | (sanen_reg & ~san_dis);
      inh_reg <= inh_set | (inh_reg & ~inh_clr);
      acf_reg <= acf_set | acf_ev | (acf_reg & ~acf_clr);
      lowb_reg <= lowb_set | lowb_ev | (lowb_reg & ~lowb_clr);
      emaj_reg <= emaj_set | emaj_ev | (emaj_reg & ~emaj_clr);
      emin_reg <= emin_set | emin_ev | (emin_reg & ~emin_clr);
      sec_reg <= sec_set | exp2 | (sec_reg & ~sec_clr);
      first_reg <= first_set | exp1 | (first_reg & ~first_clr);
      int_reg <= first_set | exp1 | lowb_crit | (int_reg & ~int_clr);
      // crit major is set only by low battery with AC failure latched, and drops on the low-battery clear read
      crit_major_reg <= lowb_crit | (crit_major_reg & ~lowb_clr);
      if (dtr_uart)
        dtr_uart_reg <= 1'b1;
      else if (dtr_force)
        dtr_uart_reg <= 1'b0;
      // unlatched request: one cycle for the command or the second expiry
      rqrst_reg <= sys_rst | exp2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word and read data

  logic [15:0] status;
  assign status = {dtr_uart_reg, 4'h0, first_reg, sec_reg, emin_reg, emaj_reg, lowb_reg, acf_reg,
                   inh_reg, restart_n, sanen_reg, swmaj_reg, swmin_reg};
  wire rd_id = RD_STB && (cmd == OFF_ID_LO || cmd == OFF_ID_HI);
  wire rd_stat = RD_STB && (cmd == OFF_STAT_LO || cmd == OFF_STAT_HI);
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      RD_DATA <= 16'h0000;
    else if (rd_id)
      RD_DATA <= BOARD_IDENTITY;
    else if (rd_stat)
      RD_DATA <= status;
    else if (RD_STB)
      RD_DATA <= 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm outputs

  logic major_reg, minor_reg;
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      major_reg <= 1'b0;
      minor_reg <= 1'b0;
    end
    else
    begin
      major_reg <= ~inh_reg & (swmaj_reg | sec_reg | emaj_reg | crit_major_reg);
      minor_reg <= ~inh_reg & (swmin_reg | acf_reg | emin_reg);
    end
  end
  assign MAJOR_ALARM = major_reg;
  assign MINOR_ALARM = minor_reg;
  assign HOST_INTERRUPT_N = ~int_reg;
  assign RESET_REQUEST_N = ~rqrst_reg;

  ////////////////////////////////////////////////////////////////////////////
  // console multiplexer: plain wiring, the serial lines are not resampled

  assign REMOTE_TERMINAL_A_DTR = dtr_uart_reg ? UART_DTR : 1'b1;
  assign REMOTE_TERMINAL_B_DTR = dtr_uart_reg ? UART_DTR : 1'b1;
  // a terminal whose carrier is down sees an idle mark line
  assign REMOTE_TERMINAL_A_TXD = TERMINAL_A_CARRIER ? CONSOLE_TXD : 1'b1;
  // terminal B is sent the console transmit line whenever its own carrier is up
  assign REMOTE_TERMINAL_B_TXD = TERMINAL_B_CARRIER ? CONSOLE_TXD : 1'b1;
  // with both carriers down the console still listens to terminal B
  assign CONSOLE_RXD = TERMINAL_A_CARRIER ? REMOTE_TERMINAL_A_RXD : REMOTE_TERMINAL_B_RXD;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_swmin_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    swmin_set |=> status[B_SWMIN]) else $error("minor flag not set");
  chk_swmin_clr: assert property (@(posedge MCLK) disable iff (!RST_N)
    swmin_clr |=> !status[B_SWMIN]) else $error("minor flag not cleared");
  chk_swmaj_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    swmaj_set |=> status[B_SWMAJ]) else $error("major flag not set");
  chk_swmaj_clr: assert property (@(posedge MCLK) disable iff (!RST_N)
    swmaj_clr |=> !status[B_SWMAJ]) else $error("major flag not cleared");
  chk_sanity_off: assert property (@(posedge MCLK) disable iff (!RST_N)
    san_dis |=> !status[B_SANEN] ##1 san_cnt_reg == '0) else $error("sanity timer still running");
  chk_restart_low: assert property (@(posedge MCLK) disable iff (!RST_N)
    san_clr |=> !status[B_RESTART_N] [*8]) else $error("restart bit not low");
  chk_inhibit_out: assert property (@(posedge MCLK) disable iff (!RST_N)
    inh_reg |=> !MAJOR_ALARM && !MINOR_ALARM) else $error("alarm passed inhibit");
  chk_acfail_force: assert property (@(posedge MCLK) disable iff (!RST_N)
    acf_set |=> status[B_ACFAIL]) else $error("ac failure flag not forced");
  chk_lowbat_clr: assert property (@(posedge MCLK) disable iff (!RST_N)
    lowb_clr && !lowb_ev |=> !status[B_LOWBAT]) else $error("low battery flag not cleared");
  chk_ext_major: assert property (@(posedge MCLK) disable iff (!RST_N)
    emaj_ev |=> status[B_EXTMAJ]) else $error("external major closure lost");
  chk_ext_minor: assert property (@(posedge MCLK) disable iff (!RST_N)
    emin_clr && !emin_ev |=> !status[B_EXTMIN]) else $error("external minor flag not cleared");
  chk_id_read: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_id |=> RD_DATA == BOARD_IDENTITY) else $error("identity wrong");
  chk_stat_read: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_stat |=> RD_DATA[14:11] == 4'h0 && RD_DATA[15] == $past(dtr_uart_reg)) else $error("status wrong");
  chk_rdata_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    !RD_STB |=> $stable(RD_DATA)) else $error("read data changed without a read");
  // a clearing read loses against a hardware set in the same cycle, hence the exclusions
  chk_first_clr: assert property (@(posedge MCLK) disable iff (!RST_N)
    first_clr && !exp1 |=> !status[B_FIRST]) else $error("first timeout flag not cleared");
  sequence first_exp_s;
    exp1;
  endsequence
  chk_first_int: assert property (@(posedge MCLK) disable iff (!RST_N)
    first_exp_s |=> !HOST_INTERRUPT_N && status[B_FIRST]) else $error("first expiry missed");
  chk_second_rst: assert property (@(posedge MCLK) disable iff (!RST_N)
    exp2 |=> !RESET_REQUEST_N && status[B_SECOND]) else $error("second expiry missed");
  chk_sys_reset: assert property (@(posedge MCLK) disable iff (!RST_N)
    sys_rst |=> !RESET_REQUEST_N) else $error("reset request missing");
  chk_int_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    int_clr && !first_set && !exp1 && !lowb_crit |=> HOST_INTERRUPT_N) else $error("interrupt stuck");
  sequence crit_low_s;
    lowb_ev && acf_reg;
  endsequence
  chk_crit_int: assert property (@(posedge MCLK) disable iff (!RST_N)
    crit_low_s |=> !HOST_INTERRUPT_N && crit_major_reg) else $error("critical low battery missed");
  chk_crit_major: assert property (@(posedge MCLK) disable iff (!RST_N)
    crit_major_reg && !inh_reg |=> MAJOR_ALARM) else $error("critical major alarm missing");
  chk_minor_out: assert property (@(posedge MCLK) disable iff (!RST_N)
    swmin_reg && !inh_reg |=> MINOR_ALARM) else $error("software minor alarm not driven");
  chk_dtr_force: assert property (@(posedge MCLK) disable iff (!RST_N)
    !status[B_DTR_UART] |-> REMOTE_TERMINAL_A_DTR && REMOTE_TERMINAL_B_DTR) else $error("dtr not forced");
  chk_dtr_uart: assert property (@(posedge MCLK) disable iff (!RST_N)
    status[B_DTR_UART] |-> REMOTE_TERMINAL_A_DTR == UART_DTR && REMOTE_TERMINAL_B_DTR == UART_DTR)
    else $error("dtr not handed to uart");
  chk_mux_prio: assert property (@(posedge MCLK) disable iff (!RST_N)
    TERMINAL_A_CARRIER |-> CONSOLE_RXD == REMOTE_TERMINAL_A_RXD) else $error("priority lost");
  chk_mux_mirror: assert property (@(posedge MCLK) disable iff (!RST_N)
    TERMINAL_B_CARRIER |-> REMOTE_TERMINAL_B_TXD == CONSOLE_TXD) else $error("terminal b mirror lost");
  chk_mux_b_path: assert property (@(posedge MCLK) disable iff (!RST_N)
    !TERMINAL_A_CARRIER |-> CONSOLE_RXD == REMOTE_TERMINAL_B_RXD && REMOTE_TERMINAL_A_TXD)
    else $error("terminal b path wrong");
  chk_reserved_nop: assert property (@(posedge MCLK) disable iff (!RST_N)
    RD_STB && cmd inside {[6'h38:6'h3D]} && !acf_ev && !lowb_ev && !emaj_ev && !emin_ev && !san_expire
    && rst_cnt_reg == '0 |=> $stable(status)) else $error("reserved read changed state");

endmodule
`default_nettype wire

// ===== host_reader.sv
// host cpu model: issues single read cycles on the card's command bus
// assumes it shares MCLK with the card
`timescale 1ns/10ps
`default_nettype none
module host_reader (
  input wire logic clk,
  output logic rd_stb,
  output logic [5:0] rd_addr,
  input wire logic [15:0] rd_data
);
  initial
  begin
    rd_stb = 1'b0;
    rd_addr = 6'h3F;
  end
  // reads are the only cycle the card takes, so there is no write path
  task automatic read_at(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    rd_stb <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    rd_addr <= ~a;
    #1;
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// ===== alarm_interface_read_command_unit_tb.sv
// self-checking bench for the alarm card read-command unit
// assumes the host model owns the read bus; the bench drives pins and serial lines
`timescale 1ns/10ps
`default_nettype none
module alarm_interface_read_command_unit_tb;
  import alarm_pkg::*;
  localparam int SAN = 100;
  localparam logic [15:0] ID = 16'h1234; // arbitrary identity value
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_stb, int_n, rq_n, major, minor, con_rxd, a_txd, b_txd, a_dtr, b_dtr;
  logic [5:0] rd_addr;
  logic [15:0] rd_data, d;
  logic [3:0] ext_n = 4'hF;
  logic car_a = 1'b0, car_b = 1'b0, con_txd = 1'b1, uart_dtr = 1'b1, a_rxd = 1'b1, b_rxd = 1'b1;
  int errors = 0;
  int total_checks = 0;
  always #25 mclk = ~mclk;
  host_reader host_reader_i (.clk(mclk), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data));
  alarm_interface_read_command_unit #(.SANITY_CYC(SAN), .RESTART_CYCLES(20), .BOARD_IDENTITY(ID))
    alarm_interface_read_command_unit_i (.MCLK(mclk), .RST_N(rst_n), .RD_STB(rd_stb), .RD_ADDR(rd_addr),
    .RD_DATA(rd_data), .HOST_INTERRUPT_N(int_n), .RESET_REQUEST_N(rq_n), .MAJOR_ALARM(major),
    .MINOR_ALARM(minor), .AC_FAIL_N(ext_n[0]), .LOW_BATTERY_N(ext_n[1]), .EXT_MAJOR_N(ext_n[2]),
    .EXT_MINOR_N(ext_n[3]), .TERMINAL_A_CARRIER(car_a), .TERMINAL_B_CARRIER(car_b),
    .CONSOLE_TXD(con_txd), .CONSOLE_RXD(con_rxd), .UART_DTR(uart_dtr), .REMOTE_TERMINAL_A_TXD(a_txd),
    .REMOTE_TERMINAL_A_RXD(a_rxd), .REMOTE_TERMINAL_B_TXD(b_txd), .REMOTE_TERMINAL_B_RXD(b_rxd),
    .REMOTE_TERMINAL_A_DTR(a_dtr), .REMOTE_TERMINAL_B_DTR(b_dtr));
  ////////////////////////////////////////////////////////////
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic rd(input logic [5:0] a);
    host_reader_i.read_at(a, d);
  endtask
  task automatic status_is(input logic [15:0] exp);
    rd(OFF_STAT_LO);
    check_word(d, exp);
  endtask
  task automatic pulse(input logic [3:0] low);
    @(posedge mclk);
    ext_n <= ~low;
    repeat (2) @(posedge mclk);
    ext_n <= 4'hF;
    repeat (5) @(posedge mclk);
  endtask
  task automatic t_identity();
    rd(OFF_ID_LO);
    check_word(d, ID);
    rd(OFF_ID_HI);
    check_word(d, ID);
    rd(OFF_STAT_HI);
    check_word(d, 16'h0008);
    check_bit(a_dtr & b_dtr, 1'b1);
  endtask
  task automatic t_flags();
    logic [1:0] al;
    for (int k = 0; k < 10; k++)
    begin
      if (k == 3)
        continue;
      al = (k == 1 || k == 7 || k == 9) ? 2'b10 : (k == 0 || k == 5 || k == 8) ? 2'b01 : 2'b00;
      rd(6'h20 + 6'(2 * k));
      status_is(16'h0008 | (16'h0001 << k));
      check_word({14'h0000, major, minor}, {14'h0000, al});
      rd(6'h21 + 6'(2 * k));
      status_is(16'h0008);
      check_word({14'h0000, major, minor}, 16'h0000);
    end
  endtask
  task automatic t_inhibit_irq();
    rd(CMD_SWMAJ_SET);
    rd(CMD_INH_SET);
    status_is(16'h001A);
    check_bit(major, 1'b0);
    rd(CMD_INH_CLR);
    status_is(16'h000A);
    check_bit(major, 1'b1);
    rd(CMD_SWMAJ_CLR);
    rd(CMD_FIRST_SET);
    status_is(16'h0408);
    check_bit(int_n, 1'b0);
    rd(CMD_FIRST_CLR);
    status_is(16'h0008);
    check_bit(int_n, 1'b0);
    rd(CMD_INT_CLR);
    status_is(16'h0008);
    check_bit(int_n, 1'b1);
    rd(CMD_SYS_RESET);
    check_bit(rq_n, 1'b0);
    @(posedge mclk);
    #1;
    check_bit(rq_n, 1'b1);
  endtask
  task automatic t_reserved();
    // every undecoded offset, the dead 0x26 included, must return zero and touch nothing
    for (int a = 0; a < 64; a++)
      if (a == 2 || a == 3 || (a > 5 && a < 32) || a == 38 || (a > 55 && a < 62))
      begin
        rd(6'(a));
        check_word(d, 16'h0000);
      end
    status_is(16'h0008);
    check_word({13'h0000, int_n, rq_n, major | minor}, 16'h0006);
  endtask
  task automatic t_dtr();
    rd(CMD_DTR_UART);
    status_is(16'h8008);
    @(posedge mclk);
    uart_dtr <= 1'b0;
    #1;
    check_bit(a_dtr | b_dtr, 1'b0);
    rd(CMD_DTR_FORCE);
    status_is(16'h0008);
    check_bit(a_dtr & b_dtr, 1'b1);
  endtask
  task automatic t_sanity();
    rd(CMD_SAN_EN);
    rd(CMD_SAN_CLR);
    status_is(16'h0004);
    repeat (22) @(posedge mclk);
    status_is(16'h000C);
    repeat (SAN - 15) @(posedge mclk);
    status_is(16'h040C);
    check_word({14'h0000, int_n, major}, 16'h0000);
    repeat (SAN - 10) @(posedge mclk);
    status_is(16'h060C);
    check_bit(major, 1'b1);
    rd(CMD_SAN_DIS);
    rd(CMD_SEC_CLR);
    rd(CMD_FIRST_CLR);
    rd(CMD_INT_CLR);
    status_is(16'h0008);
  endtask
  task automatic t_inputs();
    pulse(4'b0001);
    status_is(16'h0028);
    check_word({14'h0000, int_n, minor}, 16'h0003);
    pulse(4'b0010);
    status_is(16'h0068);
    check_word({14'h0000, int_n, major}, 16'h0001);
    rd(CMD_LOWB_CLR);
    rd(CMD_ACF_CLR);
    rd(CMD_INT_CLR);
    pulse(4'b0010);
    status_is(16'h0048);
    check_word({14'h0000, int_n, major}, 16'h0002);
    rd(CMD_LOWB_CLR);
    pulse(4'b1100);
    status_is(16'h0188);
    check_word({14'h0000, major, minor}, 16'h0003);
  endtask
  task automatic t_mux();
    for (int c = 0; c < 8; c++)
    begin
      @(posedge mclk);
      {car_a, car_b, con_txd} <= 3'(c);
      a_rxd <= c[0];
      b_rxd <= ~c[0];
      #1;
      if (car_a)
        check_word({14'h0000, a_txd, con_rxd}, {14'h0000, c[0], c[0]});
      else
        check_word({14'h0000, a_txd, con_rxd}, {14'h0000, 1'b1, ~c[0]});
      check_bit(b_txd, car_b ? c[0] : 1'b1);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_identity();
    t_flags();
    t_inhibit_irq();
    t_reserved();
    t_dtr();
    t_sanity();
    t_inputs();
    t_mux();
    complete_run();
  end
  // the whole sequence needs under a thousand cycles; this margin only catches a hang
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
